/* design/burst_counter.sv */
// Two-bit wrapping burst counter, linear or interleaved
`timescale 1ns/1ps
`default_nettype none
module burst_counter (
    input  wire logic mclk,
    input  wire logic rst_b,
    burst_if.cnt      bif
);
    import sram_port_pkg::*;

    logic [1:0] start_q;
    logic [1:0] cnt_q;
    logic [1:0] start_d;
    logic [1:0] cnt_d;

    always_comb begin
        start_d = bif.load ? bif.start : start_q;
        cnt_d   = bif.load ? CNT_RST : (bif.step ? 2'(cnt_q + CNT_STEP) : cnt_q);
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            start_q <= CNT_RST;
            cnt_q   <= CNT_RST;
        end else begin
            start_q <= start_d;
            cnt_q   <= cnt_d;
        end
    end

    // Wrap within four locations
    assign bif.low_q = bif.interleaved ? (start_q ^ cnt_q) : 2'(start_q + cnt_q); // R20
    assign bif.low_d = bif.interleaved ? (start_d ^ cnt_d) : 2'(start_d + cnt_d); // R20

    AST_INTERLEAVE_XOR: assert property (@(posedge mclk) disable iff (!rst_b) // R20
        bif.interleaved && !bif.load && bif.step ##1 bif.interleaved
        |-> bif.low_q == (start_q ^ cnt_q) && cnt_q == 2'($past(cnt_q) + CNT_STEP))
        else $error("Interleaved counter did not step by xor");
endmodule
`default_nettype wire

/* design/sram_array.sv */
// Storage array with per-lane write and registered flow-through read
`timescale 1ns/1ps
`default_nettype none
module sram_array #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
    parameter int LANES  = sram_port_pkg::LANES_DEF,
    parameter int LANE_W = sram_port_pkg::LANE_W_DEF
) (
    input  wire logic                      mclk,
    input  wire logic                      rst_b,
    input  wire logic [ADDR_W-1:0]         addr,
    input  wire logic [LANES-1:0]          lane_we,
    input  wire logic [LANES*LANE_W-1:0]   wdata,
    input  wire logic [LANES-1:0]          wpar,
    output var  logic [LANES*LANE_W-1:0]   rdata,
    output var  logic [LANES-1:0]          rpar
);
    import sram_port_pkg::*;

    for (genvar i = 0; i < LANES; i++) begin : g_lane
        logic [LANE_W:0] mem [2**ADDR_W];

        // Parity bit rides with its byte lane
        always_ff @(posedge mclk) begin
            if (lane_we[i]) begin
                mem[addr] <= {wpar[i], wdata[i*LANE_W +: LANE_W]}; // R12 R15
            end
        end

        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                rdata[i*LANE_W +: LANE_W] <= '0;
                rpar[i]                   <= 1'b0;
            end else begin
                {rpar[i], rdata[i*LANE_W +: LANE_W]} <= mem[addr]; // R13
            end
        end
    end
endmodule
`default_nettype wire

/* design/sync_flowthrough_sram_port.sv */
// Synchronous flow-through burst SRAM port, memory side
//
// Overview of operation
// R01: Selected only when first select low, second high, third low.
// R02: Chip selects are sampled only when a new external address loads.
// R03: Processor strobe is ignored while first select is sampled high.
// R04: Output enable is asynchronous; low drives data pins, high tristates them.
// R05: First read clock after deselect keeps outputs tristated.
// R06: Sampled advance during a burst steps the burst address.
// R07: Accepted processor strobe captures address and loads low two bits into counter.
// R08: Controller strobe captures address and loads low two bits into counter.
// R09: With both strobes asserted only the processor strobe acts.
// R10: Master drives byte-write qualifier low for byte-selective writes.
// R11: Sleep high freezes activity and keeps data; hold low for normal use.
// R12: Write data is captured on the rising clock edge.
// R13: Read data of the address at the previous edge flows out directly.
// R14: Data and parity tristated on writes, first clock after deselect, deselected.
// R15: Parity lines follow data lines and their byte lane write selects.
// R16: Order strap low selects linear, high interleaved; must stay static.
// R17: All-bytes write low writes every lane regardless of other enables.
// R18: Lane write selects are active low and need the byte-write qualifier.
// R19: Advance is active low and steps the counter only during a burst.
// R20: Counter wraps in four; linear adds one, interleaved xors a count.
`timescale 1ns/1ps
`default_nettype none
module sync_flowthrough_sram_port #(
    parameter int ADDR_W = sram_port_pkg::ADDR_W_DEF,
    parameter int LANES  = sram_port_pkg::LANES_DEF,
    parameter int LANE_W = sram_port_pkg::LANE_W_DEF
) (
    input  wire logic                    mclk,
    input  wire logic                    rst_b,
    input  wire logic [ADDR_W-1:0]       addr,
    input  wire logic                    select_low_first_n,
    input  wire logic                    select_high_second,
    input  wire logic                    select_low_third_n,
    input  wire logic                    processor_addr_strobe_n,
    input  wire logic                    controller_addr_strobe_n,
    input  wire logic                    burst_advance_n,
    input  wire logic                    byte_write_qualifier_n,
    input  wire logic [LANES-1:0]        byte_lane_write_select_n,
    input  wire logic                    all_bytes_write_n,
    input  wire logic                    output_enable_n,
    input  wire logic                    sleep_request,
    input  wire logic                    burst_order_sel,
    input  wire logic [LANES*LANE_W-1:0] dq_in,
    output var  logic [LANES*LANE_W-1:0] dq_out,
    output var  logic                    dq_oe,
    input  wire logic [LANES-1:0]        parity_data_lines_in,
    output var  logic [LANES-1:0]        parity_data_lines_out,
    output var  logic                    parity_data_lines_oe
);
    import sram_port_pkg::*;

    burst_if bif ();

    logic              selected_q;
    logic              selected_d;
    logic              drive_q;
    logic              drive_d;
    logic              strap_taken_q;
    burst_order_t      order_q;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] mem_addr;
    logic              awake;
    logic              chip_sel;
    logic              p_acc;
    logic              c_acc;
    logic              load;
    logic              first_read;
    logic              write_ok;
    logic [LANES-1:0]  lane_raw;
    logic [LANES-1:0]  lane_we;

    // Strobe decode and select qualification
    always_comb begin
        awake    = !sleep_request; // R11
        chip_sel = !select_low_first_n && select_high_second && !select_low_third_n; // R01
        p_acc    = !processor_addr_strobe_n && !select_low_first_n; // R03
        c_acc    = !controller_addr_strobe_n && !p_acc; // R09
        load     = awake && (p_acc || c_acc);
    end

    // Write lane enables
    always_comb begin
        if (!all_bytes_write_n) begin
            lane_raw = '1; // R17
        end else if (!byte_write_qualifier_n) begin
            lane_raw = ~byte_lane_write_select_n; // R18 R10
        end else begin
            lane_raw = '0; // R18
        end
        // Processor-strobe load cycle never writes; controller strobe may
        if (!awake) begin
            write_ok = 1'b0;
        end else if (load) begin
            write_ok = c_acc && chip_sel; // R09
        end else begin
            write_ok = selected_q;
        end
        lane_we = write_ok ? lane_raw : '0; // R15
    end

    // Selection is re-evaluated only on an external address load
    always_comb begin
        selected_d = (load && awake) ? chip_sel : selected_q; // R02
        first_read = load && chip_sel && !selected_q;
        drive_d    = awake && selected_d && !first_read && !(|lane_we); // R05 R14
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            selected_q <= SEL_RST;
        end else begin
            selected_q <= selected_d; // R01 R02
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= '0;
        end else if (load && chip_sel) begin
            addr_q <= addr; // R07 R08
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            drive_q <= DRIVE_RST;
        end else begin
            drive_q <= drive_d; // R14
        end
    end

    // Order strap is caught once after reset release
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            order_q       <= burst_order_t'(ORDER_RST);
            strap_taken_q <= 1'b0;
        end else if (!strap_taken_q) begin
            order_q       <= burst_order_sel ? ORDER_INTERLEAVED : ORDER_LINEAR; // R16
            strap_taken_q <= 1'b1;
        end
    end

    // Burst counter control
    always_comb begin
        bif.load        = load && chip_sel; // R07 R08
        bif.start       = addr[1:0];
        bif.step        = awake && !load && selected_q && !burst_advance_n; // R06 R19
        bif.interleaved = (order_q == ORDER_INTERLEAVED); // R16
    end

    burst_counter u_counter (
        .mclk  (mclk),
        .rst_b (rst_b),
        .bif   (bif)
    );

    // Address in effect after this edge feeds read and write
    always_comb begin
        mem_addr = (load && chip_sel) ? addr : addr_q;
        mem_addr[1:0] = bif.low_d; // R13
    end

    sram_array #(
        .ADDR_W (ADDR_W),
        .LANES  (LANES),
        .LANE_W (LANE_W)
    ) u_array (
        .mclk    (mclk),
        .rst_b   (rst_b),
        .addr    (mem_addr),
        .lane_we (lane_we),
        .wdata   (dq_in),
        .wpar    (parity_data_lines_in),
        .rdata   (dq_out),
        .rpar    (parity_data_lines_out)
    );

    // Asynchronous output enable gates the registered drive window
    always_comb begin
        dq_oe                = drive_q && !output_enable_n && !sleep_request; // R04 R11
        parity_data_lines_oe = drive_q && !output_enable_n && !sleep_request; // R15
    end

    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);

    AST_SELECT_DECODE: assert property ( // R01
        load && !chip_sel |=> !selected_q && !dq_oe)
        else $error("Bad select combination did not deselect");

    AST_SELECT_HELD_IN_BURST: assert property ( // R02
        !load && selected_q ##0 !select_high_second |=> selected_q)
        else $error("Selects sampled during an advanced cycle");

    AST_PSTROBE_BLOCKED: assert property ( // R03
        !processor_addr_strobe_n && select_low_first_n && controller_addr_strobe_n
        |=> addr_q == $past(addr_q) && selected_q == $past(selected_q))
        else $error("Processor strobe acted with first select high");

    AST_OE_HIGH_TRISTATES: assert property ( // R04
        output_enable_n |-> !dq_oe && !parity_data_lines_oe)
        else $error("Data driven with output enable high");

    AST_FIRST_READ_HIDDEN: assert property ( // R05
        !selected_q && load && chip_sel |=> !dq_oe ##1 (dq_oe || output_enable_n
            || !selected_q || $past(|lane_we) || sleep_request))
        else $error("Output window after deselect wrong");

    AST_LINEAR_STEP: assert property ( // R06
        order_q == ORDER_LINEAR && bif.step
        |=> bif.low_q == 2'($past(bif.low_q) + CNT_STEP))
        else $error("Linear burst did not advance by one");

    AST_NO_ADVANCE_HOLD: assert property ( // R19
        awake && !load && burst_advance_n |=> $stable(bif.low_q))
        else $error("Burst address moved without advance");

    AST_PSTROBE_LOAD: assert property ( // R07
        awake && p_acc && chip_sel
        |=> addr_q == $past(addr) && bif.low_q == $past(addr[1:0]))
        else $error("Processor strobe did not load address");

    AST_CSTROBE_LOAD: assert property ( // R08
        awake && !controller_addr_strobe_n && processor_addr_strobe_n && chip_sel
        |=> addr_q == $past(addr) && bif.low_q == $past(addr[1:0]))
        else $error("Controller strobe did not load address");

    AST_PSTROBE_PRIORITY: assert property ( // R09
        p_acc && !controller_addr_strobe_n |-> lane_we == '0)
        else $error("Controller strobe acted beside processor strobe");

    AST_SLEEP_QUIET: assert property ( // R11
        sleep_request |-> lane_we == '0 && !dq_oe ##1 $stable(addr_q))
        else $error("Activity during sleep");

    AST_WRITE_TRISTATE: assert property ( // R14
        |lane_we |=> !dq_oe && !parity_data_lines_oe)
        else $error("Outputs driven in write data cycle");

    AST_ALL_BYTES: assert property ( // R17
        write_ok && !all_bytes_write_n |-> lane_we == '1)
        else $error("All-bytes write missed a lane");

    AST_QUALIFIER_NEEDED: assert property ( // R18
        all_bytes_write_n && byte_write_qualifier_n |-> lane_we == '0)
        else $error("Lane written without qualifier");

    AST_STRAP_STATIC: assert property ( // R16
        strap_taken_q |=> $stable(order_q))
        else $error("Burst order changed after capture");

    AST_STRAP_MATCH: assert property ( // R16
        strap_taken_q |-> bif.interleaved == burst_order_sel)
        else $error("Burst order does not follow the strap");

    AST_WRITE_LANES: assert property ( // R18
        write_ok && all_bytes_write_n && !byte_write_qualifier_n
        |-> lane_we == ~byte_lane_write_select_n)
        else $error("Byte lane write selects not honoured");

    AST_PLOAD_NO_WRITE: assert property ( // R07
        p_acc
        |-> lane_we == '0)
        else $error("Write on a processor strobe load cycle");

    AST_CSTROBE_WRITE: assert property ( // R08
        awake && c_acc && chip_sel && !all_bytes_write_n
        |-> lane_we == '1)
        else $error("Controller strobe write missed a lane");

    AST_DESELECT_TRISTATE: assert property ( // R14
        !selected_q
        |-> !dq_oe && !parity_data_lines_oe)
        else $error("Outputs driven while deselected");

    AST_DESELECT_NO_STEP: assert property ( // R19
        !selected_q && !load
        |=> $stable(bif.low_q))
        else $error("Burst address moved while deselected");

    AST_SLEEP_FROZEN: assert property ( // R11
        sleep_request
        |=> $stable(bif.low_q) && $stable(selected_q) && !drive_q)
        else $error("State moved during sleep");

    AST_FLOW_READ_STEADY: assert property ( // R13
        !(|lane_we) ##1 awake && !load && !bif.step && !(|lane_we)
        |=> $stable(dq_out) && $stable(parity_data_lines_out))
        else $error("Read data moved with address and memory unchanged");

    COV_PSTROBE_READ: cover property (
        p_acc && chip_sel ##1 !burst_advance_n [*3]);
    COV_CSTROBE_WRITE: cover property (
        c_acc && chip_sel && |lane_we);
    COV_BOTH_STROBES: cover property (
        p_acc && !controller_addr_strobe_n && chip_sel);
    COV_INTERLEAVED_BURST: cover property (
        bif.interleaved && bif.step ##1 bif.step ##1 bif.step);
    COV_DESELECT_IDLE: cover property (
        !selected_q && !load && !burst_advance_n);
endmodule
`default_nettype wire

/* pkg/burst_if.sv */
// Carrier between the port control and the burst counter
`timescale 1ns/1ps
`default_nettype none
interface burst_if;
    logic       load;
    logic [1:0] start;
    logic       step;
    logic       interleaved;
    logic [1:0] low_q;
    logic [1:0] low_d;
    modport ctrl (output load, start, step, interleaved, input low_q, low_d);
    modport cnt  (input load, start, step, interleaved, output low_q, low_d);
endinterface
`default_nettype wire

/* pkg/sram_port_pkg.sv */
// Shared constants for the flow-through burst SRAM port
`default_nettype none
package sram_port_pkg;
    localparam int         ADDR_W_DEF  = 18;
    localparam int         LANES_DEF   = 4;
    localparam int         LANE_W_DEF  = 8;
    localparam int         BURST_W     = 2;
    localparam logic       SEL_RST     = 1'b0;
    localparam logic       DRIVE_RST   = 1'b0;
    localparam logic       ORDER_RST   = 1'b1;
    localparam logic [1:0] CNT_RST     = 2'h0;
    localparam logic [1:0] CNT_STEP    = 2'h1;
    typedef enum logic {ORDER_LINEAR, ORDER_INTERLEAVED} burst_order_t;
endpackage
`default_nettype wire

/* sim/bus_master_model.sv */
// Bus master model driving the flow-through SRAM port
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
    input  wire logic        mclk,
    input  wire logic [31:0] dq_out,
    input  wire logic        dq_oe,
    input  wire logic [3:0]  par_out,
    input  wire logic        par_oe,
    output var  logic [13:0] ctl,
    output var  logic [17:0] addr,
    output var  logic [31:0] dq_wire,
    output var  logic [3:0]  par_wire
);
    logic [31:0] data;
    logic        drive;
    logic [31:0] last_q;
    logic [3:0]  last_par_q;
    initial begin
        ctl        = 14'h0FFA;
        addr       = 18'h0;
        data       = 32'h0;
        drive      = 1'b0;
        last_q     = 32'h0;
        last_par_q = 4'h0;
    end
    // Released lines show the inverse of their last level
    always @(posedge mclk) begin
        last_q     <= dq_wire;
        last_par_q <= par_wire;
    end
    always_comb begin
        dq_wire  = dq_oe ? dq_out : (drive ? data : ~last_q);
        par_wire = par_oe ? par_out
                 : (drive ? {data[24], data[16], data[8], data[0]} : ~last_par_q);
    end
    // One bus cycle; byte writes come with a low qualifier
    task automatic put(input logic [13:0] c, input logic [17:0] a,
                       input logic [31:0] d, input logic dr);
        ctl   = c;
        addr  = a;
        data  = d;
        drive = dr;
    endtask
endmodule
`default_nettype wire

/* sim/tb_sync_flowthrough_sram_port.sv */
// Self-checking bench for the flow-through burst SRAM port
`timescale 1ns/1ps
`default_nettype none
module tb_sync_flowthrough_sram_port;
    typedef struct packed {
        logic [13:0] c;
        logic [17:0] a;
        logic [31:0] d;
        logic [2:0]  f;
        logic [31:0] e;
    } row_t;
    localparam logic [31:0] D0  = 32'h1111_1100;
    localparam logic [31:0] D1  = 32'h2222_2201;
    localparam logic [31:0] D1B = 32'h2222_225A;
    localparam logic [31:0] D2  = 32'h3333_3302;
    localparam logic [31:0] D3  = 32'h4444_4403;
    localparam logic [31:0] D4  = 32'h1111_1104;
    logic        mclk;
    logic        rst_b;
    logic        burst_order_sel;
    logic [13:0] ctl;
    logic [17:0] addr;
    logic [31:0] dq_wire;
    logic [3:0]  par_wire;
    logic [31:0] dq_out;
    logic        dq_oe;
    logic [3:0]  par_out;
    logic        par_oe;
    int          errors;
    int          compares;
    logic [31:0] lin [3] = '{D2, D3, D4};
    // Row flags: drive data, check data, expected drive enable
    row_t rows [22] = '{
        '{14'h07EA, 18'h100, D0, 3'h4, 32'h0},
        '{14'h07EA, 18'h101, D1, 3'h4, 32'h0},
        '{14'h07EA, 18'h102, D2, 3'h4, 32'h0},
        '{14'h07EA, 18'h103, D3, 3'h4, 32'h0},
        '{14'h0F2A, 18'h101, 32'h5A5A_5A5A, 3'h4, 32'h0},
        '{14'h086A, 18'h101, 32'hFFFF_FFFF, 3'h7, D1B},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D0},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D3},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D2},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D1B},
        '{14'h0FFA, 18'h0, 32'h0, 3'h3, D1B},
        '{14'h1FFA, 18'h0, 32'h0, 3'h2, D1B},
        '{14'h0FF6, 18'h103, 32'h0, 3'h3, D1B},
        '{14'h07E2, 18'h100, 32'hDEAD_BEEF, 3'h7, D0},
        '{14'h1F3A, 18'h0, D4, 3'h6, D0},
        '{14'h0FFA, 18'h0, 32'h0, 3'h3, D4},
        '{14'h0FE8, 18'h0, 32'h0, 3'h0, 32'h0},
        '{14'h0FDA, 18'h0, 32'h0, 3'h0, 32'h0},
        '{14'h0FF2, 18'h102, 32'h0, 3'h2, D2},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D3},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D4},
        '{14'h0FDA, 18'h0, 32'h0, 3'h3, D1B}
    };
    sync_flowthrough_sram_port DUT (
        .mclk                     (mclk),
        .rst_b                    (rst_b),
        .addr                     (addr),
        .select_low_first_n       (ctl[2]),
        .select_high_second       (ctl[1]),
        .select_low_third_n       (ctl[0]),
        .processor_addr_strobe_n  (ctl[3]),
        .controller_addr_strobe_n (ctl[4]),
        .burst_advance_n          (ctl[5]),
        .byte_write_qualifier_n   (ctl[6]),
        .byte_lane_write_select_n (ctl[10:7]),
        .all_bytes_write_n        (ctl[11]),
        .output_enable_n          (ctl[12]),
        .sleep_request            (ctl[13]),
        .burst_order_sel          (burst_order_sel),
        .dq_in                    (dq_wire),
        .dq_out                   (dq_out),
        .dq_oe                    (dq_oe),
        .parity_data_lines_in     (par_wire),
        .parity_data_lines_out    (par_out),
        .parity_data_lines_oe     (par_oe)
    );
    bus_master_model master (
        .mclk     (mclk),
        .dq_out   (dq_out),
        .dq_oe    (dq_oe),
        .par_out  (par_out),
        .par_oe   (par_oe),
        .ctl      (ctl),
        .addr     (addr),
        .dq_wire  (dq_wire),
        .par_wire (par_wire)
    );
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic end_sim;
        if (errors == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // One bus cycle, then the outputs after its edge
    task automatic cyc(input logic [13:0] c, input logic [17:0] a, input logic [31:0] d,
                       input logic [2:0] f, input logic [31:0] e);
        master.put(c, a, d, f[2]);
        @(posedge mclk);
        #1;
        check("dq_oe", {31'h0, dq_oe}, {31'h0, f[0]});
        check("par_oe", {31'h0, par_oe}, {31'h0, f[0]});
        if (f[1]) begin
            check("dq_out", dq_out, e);
            check("parity", {28'h0, par_out}, {28'h0, e[24], e[16], e[8], e[0]});
        end
    endtask
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    initial begin
        #2000;
        errors++;
        end_sim();
    end
    initial begin
        errors          = 0;
        compares        = 0;
        rst_b           = 1'b0;
        burst_order_sel = 1'b1;
        repeat (12) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        foreach (rows[i]) begin
            cyc(rows[i].c, rows[i].a, rows[i].d, rows[i].f, rows[i].e);
        end
        // Sleep drops the drive at once and blocks the write
        master.put(14'h27EA, 18'h103, D0, 1'b1);
        #1;
        check("sleep_oe", {31'h0, dq_oe}, 32'h0);
        @(posedge mclk);
        #1;
        cyc(14'h0FEA, 18'h103, 32'h0, 3'h3, D3);
        // Reset in mid-run, then linear order from the strap
        rst_b           = 1'b0;
        burst_order_sel = 1'b0;
        #1;
        check("rst_oe", {31'h0, dq_oe}, 32'h0);
        check("rst_dq", dq_out, 32'h0);
        check("rst_par", {28'h0, par_out}, 32'h0);
        repeat (2) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        cyc(14'h0FEA, 18'h101, 32'h0, 3'h2, D1B);
        foreach (lin[i]) begin
            cyc(14'h0FDA, 18'h0, 32'h0, 3'h3, lin[i]);
        end
        // Bad selects mid-burst are ignored; linear order wraps
        cyc(14'h0FD8, 18'h0, 32'h0, 3'h3, D1B);
        end_sim();
    end
endmodule
`default_nettype wire
